// [hdl/ext_irq_level_trigger.sv]
// external interrupt trigger, level and arbitration block
//
// Operation
// RULE1: pulse mode samples line each edge; a high sets flag, sampling stops
// RULE2: pulse mode resumes sampling only after software clears the flag
// RULE3: level mode samples every edge; flag follows the sampled level
// RULE4: level mode ignores a write of one to the flag
// RULE5: sources in level mode hold the line until the core accepts
// RULE6: each source has a 3-bit level 0 to 7, reset 0
// RULE7: the core refuses requests below its status word level mask
// RULE8: among pending enabled causes the highest level is forwarded
// RULE9: equal levels go to the lowest vector number first
// RULE10: losing causes stay pending until higher ones are accepted
// RULE11: a higher cause arriving replaces vector and level on output
// RULE12: each source has a trigger select bit, one is level, reset zero
// RULE13: software must set level trigger mode for all eight sources
// RULE14: setup register holds upper trigger D12, level D10-8, lower D4, D2-0
// RULE15: setup register 2 holds voltage detect upper, lowspeed timer lower
// RULE16: a cause arbitrates only when its enable bit is one, reset zero
// RULE17: software must set the global enable before any request
// RULE18: pulse mode write of one to the flag clears it and re-arms
//
// Implementation choice: the address-and-strobe port.
`include "irq_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module ext_irq_level_trigger (
    // clock, reset, clock enable
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // register port
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    // source request lines, index order: port0, port1, stopwatch,
    // clock timer, lowspeed timer, voltage detect, display, pwm capture
    input wire logic [7:0] src_line_i,
    // request to the core
    output logic irq_req_o,
    output logic [7:0] irq_vector_o,
    output logic [2:0] irq_level_o,
    input wire logic irq_ack_i,
    // block event interrupt
    output logic evt_irq_o
);
    // setup register decode, used for writes only; reads decode in the read mux
    function automatic logic setup_hit(input logic [15:0] a, input int k);
        logic [15:0] base;
        base = `OFF_SETUP0;
        setup_hit = (a == base + 16'(2 * k));
    endfunction : setup_hit

    // configuration state
    irq_pkg::prio_t prio [irq_pkg::NSRC];
    irq_pkg::src_vec_t trig_sel;
    irq_pkg::src_vec_t src_enable;
    logic arbiter_global_enable;
    irq_pkg::evt_vec_t evt_status;
    irq_pkg::evt_vec_t evt_mask;

    // flags and arbitration
    irq_pkg::src_vec_t source_pending_flag;
    irq_pkg::src_vec_t flag_clr;
    irq_pkg::evt_vec_t evt_set;
    logic [7:0] next_vector;
    logic [15:0] next_rdata;
    logic [15:0] setup_word [4];

    arb_if arb ();

    // named views of the fields
    wire logic trig_sel_port0 = trig_sel[0];
    wire logic trig_sel_port1 = trig_sel[1];
    wire logic trig_sel_stopwatch = trig_sel[2];
    wire logic trig_sel_clock_timer = trig_sel[3];
    wire logic trig_sel_lowspeed_timer = trig_sel[4];
    wire logic trig_sel_voltage_detect = trig_sel[5];
    wire logic trig_sel_display = trig_sel[6];
    wire logic trig_sel_pwm_capture = trig_sel[7];
    wire irq_pkg::prio_t prio_lowspeed_timer = prio[4];
    wire irq_pkg::prio_t prio_voltage_detect = prio[5];

    // strobe decode
    wire logic wr_ctrl = wr_i && (addr_i == `OFF_CTRL);
    wire logic wr_flags = wr_i && (addr_i == `OFF_FLAGS);
    wire logic wr_enable = wr_i && (addr_i == `OFF_ENABLE);
    wire logic wr_evt_status = wr_i && (addr_i == `OFF_EVT_STATUS);
    wire logic wr_evt_mask = wr_i && (addr_i == `OFF_EVT_MASK);

    // write of one to a flag bit asks for a clear; level sources ignore it
    assign flag_clr = wr_flags ? wdata_i[7:0] : 8'h00;

    // per-source flag logic
    generate
        for (genvar s = 0; s < irq_pkg::NSRC; s++) begin : g_src
            src_flag u_flag (
                .clk_i(clk_i),
                .resetn_i(resetn_i),
                .ce_i(ce_i),
                .line_i(src_line_i[s]),
                .level_mode_i(trig_sel[s]),
                .clr_i(flag_clr[s]),
                .flag_o(source_pending_flag[s])
            );
        end
    endgenerate

    // setup registers: two sources each, upper in bits 12 and 10:8
    generate
        for (genvar k = 0; k < 4; k++) begin : g_setup
            wire logic hit_wr = wr_i && setup_hit(addr_i, k);

            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    prio[2*k] <= `RST_PRIO;                  // RULE6
                    prio[2*k+1] <= `RST_PRIO;
                    trig_sel[2*k] <= `RST_TRIG;              // RULE12
                    trig_sel[2*k+1] <= `RST_TRIG;
                end else if (ce_i && hit_wr) begin
                    prio[2*k] <= wdata_i[`POS_PRIO_LO +: 3];    // RULE14
                    prio[2*k+1] <= wdata_i[`POS_PRIO_HI +: 3];
                    trig_sel[2*k] <= wdata_i[`POS_TRIG_LO];
                    trig_sel[2*k+1] <= wdata_i[`POS_TRIG_HI];
                end
            end

            // reserved bits read as zero
            assign setup_word[k] = {3'h0, trig_sel[2*k+1], 1'b0,
                prio[2*k+1], 3'h0, trig_sel[2*k], 1'b0, prio[2*k]};
        end
    endgenerate

    // enable bits and global enable
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            src_enable <= `RST_ENABLE;                   // RULE16
            arbiter_global_enable <= 1'b0;
        end else if (ce_i) begin
            if (wr_enable) begin
                src_enable <= wdata_i[7:0];
            end
            if (wr_ctrl) begin
                arbiter_global_enable <= wdata_i[`POS_GLOBAL_EN];
            end
        end
    end

    // candidates: pending, enabled, and the block switched on; losers
    // are not touched and simply stay pending for a later round
    assign arb.cand = arbiter_global_enable ?
        (source_pending_flag & src_enable) : 8'h00;      // RULE16 RULE10
    generate
        for (genvar p = 0; p < irq_pkg::NSRC; p++) begin : g_prio
            assign arb.prio[p] = prio[p];
        end
    endgenerate

    prio_pick u_pick (
        .bus(arb.pick)
    );

    // vector number of the current winner
    assign next_vector = `VEC_BASE + {5'h00, arb.win_idx};

    // request output re-evaluated each cycle, so a stronger cause
    // replaces vector and level while the request is up; the core
    // decides on its own mask whether to take it
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_req_o <= 1'b0;
            irq_vector_o <= 8'h00;
            irq_level_o <= 3'h0;
        end else if (ce_i) begin
            irq_req_o <= arb.win_valid;                  // RULE8
            irq_vector_o <= next_vector;                 // RULE11
            irq_level_o <= arb.win_prio;                 // RULE11
        end
    end

    // block events: request raised, request replaced, request accepted
    assign evt_set[`EVT_RAISED] = arb.win_valid && !irq_req_o;
    assign evt_set[`EVT_REPLACED] = arb.win_valid && irq_req_o &&
        (next_vector != irq_vector_o);
    assign evt_set[`EVT_ACCEPTED] = irq_ack_i && irq_req_o;

    // sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            evt_status <= 3'h0;
        end else if (ce_i) begin
            evt_status <= evt_set |
                (evt_status & ~(wr_evt_status ? wdata_i[2:0] : 3'h0));
        end
    end

    // event mask, one lets the bit through
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            evt_mask <= `RST_MASK;
        end else if (ce_i && wr_evt_mask) begin
            evt_mask <= wdata_i[2:0];
        end
    end

    // registered level output, one cycle behind the status
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            evt_irq_o <= 1'b0;
        end else if (ce_i) begin
            evt_irq_o <= |(evt_status & evt_mask);
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        next_rdata = 16'h0000;
        case (addr_i)
            `OFF_SETUP0: next_rdata = setup_word[0];
            `OFF_SETUP1: next_rdata = setup_word[1];
            `OFF_SETUP2: next_rdata = setup_word[2];     // RULE15
            `OFF_SETUP3: next_rdata = setup_word[3];
            `OFF_CTRL: next_rdata = {15'h0000, arbiter_global_enable};
            `OFF_FLAGS: next_rdata = {8'h00, source_pending_flag};
            `OFF_ENABLE: next_rdata = {8'h00, src_enable};
            `OFF_EVT_STATUS: next_rdata = {13'h0000, evt_status};
            `OFF_EVT_MASK: next_rdata = {13'h0000, evt_mask};
            default: next_rdata = 16'h0000;
        endcase
    end

    // read data stands in the cycle after the read strobe and holds while ce_i is low
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= 16'h0000;
        end else if (ce_i) begin
            rdata_o <= rd_i ? next_rdata : 16'h0000;
        end
    end
endmodule : ext_irq_level_trigger
`default_nettype wire

// [hdl/irq_defines.svh]
// constants for the external interrupt level and trigger block
`ifndef IRQ_DEFINES_SVH
`define IRQ_DEFINES_SVH

// register offsets
`define OFF_SETUP0 16'h4306
`define OFF_SETUP1 16'h4308
`define OFF_SETUP2 16'h430a
`define OFF_SETUP3 16'h430c
`define OFF_CTRL 16'h4304
`define OFF_FLAGS 16'h4316
`define OFF_ENABLE 16'h4318
`define OFF_EVT_STATUS 16'h431a
`define OFF_EVT_MASK 16'h431c

// field positions inside a level setup register and the control register
`define POS_TRIG_LO 4
`define POS_TRIG_HI 12
`define POS_PRIO_LO 0
`define POS_PRIO_HI 8
`define POS_GLOBAL_EN 0

// event status bits
`define EVT_RAISED 0
`define EVT_REPLACED 1
`define EVT_ACCEPTED 2

// reset values
`define RST_PRIO 3'h0
`define RST_TRIG 1'h0
`define RST_ENABLE 8'h00
`define RST_MASK 3'h0

// vector number of source 0, others follow in order; value is arbitrary
`define VEC_BASE 8'h04

`endif

// [hdl/irq_pkg.sv]
// types shared by the external interrupt level and trigger block
package irq_pkg;
    localparam int NSRC = 8;
    typedef logic [2:0] prio_t;
    typedef logic [2:0] src_idx_t;
    typedef logic [7:0] src_vec_t;
    typedef logic [2:0] evt_vec_t;
endpackage : irq_pkg

// [hdl/arb_if.sv]
// carrier between the register side and the priority picker
`timescale 1ns/100ps
`default_nettype none
interface arb_if;
    irq_pkg::src_vec_t cand;
    irq_pkg::prio_t prio [irq_pkg::NSRC];
    logic win_valid;
    irq_pkg::src_idx_t win_idx;
    irq_pkg::prio_t win_prio;
    modport pick (input cand, input prio,
                  output win_valid, output win_idx, output win_prio);
    modport ctl (output cand, output prio,
                 input win_valid, input win_idx, input win_prio);
endinterface : arb_if
`default_nettype wire

// [hdl/src_flag.sv]
// pending flag of one source in pulse or level trigger mode
`timescale 1ns/100ps
`default_nettype none
module src_flag (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // source side
    input wire logic line_i,
    input wire logic level_mode_i,
    input wire logic clr_i,
    output logic flag_o
);
    logic next_flag;

    // level mode follows the line and ignores writes; pulse mode holds
    always_comb begin
        if (level_mode_i) begin
            next_flag = line_i;                     // RULE3 RULE4
        end else if (!flag_o) begin
            next_flag = line_i;                     // RULE1
        end else begin
            next_flag = !clr_i;                     // RULE2 RULE18
        end
    end

    // sampling stops while a pulse flag is set, so a pulse that lands in the clear cycle is lost
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flag_o <= 1'b0;
        end else if (ce_i) begin
            flag_o <= next_flag;
        end
    end
endmodule : src_flag
`default_nettype wire

// [hdl/prio_pick.sv]
// picks the highest level candidate, lowest index on a tie
`timescale 1ns/100ps
`default_nettype none
module prio_pick (
    // candidates in, winner out
    arb_if.pick bus
);
    // scan from the top index down so an equal level lower index replaces
    always_comb begin
        bus.win_valid = 1'b0;
        bus.win_idx = 3'h0;
        bus.win_prio = 3'h0;
        for (int i = irq_pkg::NSRC - 1; i >= 0; i--) begin
            if (bus.cand[i] && (!bus.win_valid ||
                    bus.prio[i] >= bus.win_prio)) begin // RULE8 RULE9
                bus.win_valid = 1'b1;
                bus.win_idx = irq_pkg::src_idx_t'(i);
                bus.win_prio = bus.prio[i];
            end
        end
    end
endmodule : prio_pick
`default_nettype wire

// [verif/ext_irq_chk.sv]
// port checker for the interrupt level and trigger block
`timescale 1ns/100ps
`default_nettype none
module ext_irq_chk (
    // watched ports
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic irq_req_o,
    input wire logic [7:0] irq_vector_o,
    input wire logic [2:0] irq_level_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // address decode seen by the checker
    wire logic rd_ok = rd_i && ce_i;
    wire logic setup_hit = addr_i >= 16'h4306 && addr_i <= 16'h430c
        && !addr_i[0];
    // write, one quiet cycle, read back of the same setup word
    sequence s_wr_setup;
        wr_i && ce_i && setup_hit;
    endsequence
    sequence s_rd_same;
        rd_ok && addr_i == $past(addr_i, 2);
    endsequence
    property p_setup_rw;
        s_wr_setup ##1 !wr_i ##1 s_rd_same
            |=> rdata_o == ($past(wdata_i, 3) & 16'h1717);
    endproperty
    a_setup_rw: assert property (p_setup_rw)
        else $error("setup readback wrong");
    property p_setup_rsv;
        $past(rd_ok && setup_hit) |-> (rdata_o & 16'he8e8) == 16'h0000;
    endproperty
    a_setup_rsv: assert property (p_setup_rsv)
        else $error("setup reserved bits set");
    property p_ctrl_rsv;
        $past(rd_ok && addr_i == 16'h4304) |-> rdata_o[15:1] == 15'h0000;
    endproperty
    a_ctrl_rsv: assert property (p_ctrl_rsv)
        else $error("control reserved bits set");
    // a frozen cycle legally holds the last read word, so skip it
    property p_rd_idle;
        $past(ce_i) && !$past(rd_ok) |-> rdata_o == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read slot");
    property p_rd_unmapped;
        $past(rd_ok && addr_i == 16'h4300) |-> rdata_o == 16'h0000;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped)
        else $error("unmapped read not zero");
    property p_vec_range;
        irq_req_o |-> irq_vector_o inside {[8'h04:8'h0b]};
    endproperty
    a_vec_range: assert property (p_vec_range)
        else $error("vector out of range");
    // a frozen clock enable must hold the request and vector outputs
    property p_freeze;
        !ce_i |=> $stable(irq_req_o) && $stable(irq_vector_o);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("outputs moved with clock enable low");
    property p_lvl_hold;
        irq_req_o && $past(irq_req_o) && $stable(irq_vector_o)
            && !$past(wr_i) && !$past(wr_i, 2) |-> $stable(irq_level_o);
    endproperty
    a_lvl_hold: assert property (p_lvl_hold)
        else $error("level changed for same vector");
endmodule : ext_irq_chk
bind ext_irq_level_trigger ext_irq_chk u_chk (.clk_i(clk_i),
    .resetn_i(resetn_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_req_o(irq_req_o),
    .irq_vector_o(irq_vector_o), .irq_level_o(irq_level_o));
`default_nettype wire

// [verif/core_model.sv]
// processor core stand-in: accepts requests at or above its level mask
`timescale 1ns/100ps
`default_nettype none
module core_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // request from the block
    input wire logic req_i,
    input wire logic [2:0] level_i,
    input wire logic [2:0] mask_i,
    input wire logic slow_i,
    output logic ack_o
);
    logic wait_q;
    // one-cycle accept pulse; slow mode lets a cycle pass first
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_o <= 1'b0;
            wait_q <= 1'b0;
        end else begin
            wait_q <= req_i && !ack_o && !wait_q && slow_i;
            ack_o <= req_i && !ack_o && level_i >= mask_i
                && (!slow_i || wait_q);
        end
    end
endmodule : core_model
`default_nettype wire

// [verif/tb_ext_irq_level_trigger.sv]
// self-checking bench for the interrupt level and trigger block
`timescale 1ns/100ps
`default_nettype none
module tb_ext_irq_level_trigger;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic ce_i = 1'b1;
    logic [15:0] addr_i = 16'h0000;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] src_line_i = 8'h00;
    logic [2:0] mask = 3'h0;
    logic slow = 1'b0;
    logic [15:0] rdata_o;
    logic irq_req_o;
    logic [7:0] irq_vector_o;
    logic [2:0] irq_level_o;
    logic ack;
    logic evt_irq_o;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;

    // clock and hang guard; the whole run needs about a hundred cycles
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            final_report();
        end
    end

    ext_irq_level_trigger u_dut (.clk_i(clk_i), .resetn_i(resetn_i),
        .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .src_line_i(src_line_i),
        .irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o),
        .irq_level_o(irq_level_o), .irq_ack_i(ack), .evt_irq_o(evt_irq_o));
    core_model u_core (.clk_i(clk_i), .resetn_i(resetn_i),
        .req_i(irq_req_o), .level_i(irq_level_o), .mask_i(mask),
        .slow_i(slow), .ack_o(ack));

    task automatic final_report();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // writes leave one quiet cycle so strobes never meet in a time step
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask : wr

    task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 check(rdata_o, exp);
        @(posedge clk_i);
    endtask : rdchk

    task automatic chkreq(input logic [7:0] v, input logic [2:0] l);
        #1 check({15'h0000, irq_req_o}, 16'h0001);
        check({8'h00, irq_vector_o}, {8'h00, v});
        check({13'h0000, irq_level_o}, {13'h0000, l});
    endtask : chkreq

    task automatic t_reset();
        for (int i = 0; i < 4; i++)
            rdchk(16'h4306 + 16'(2 * i), 16'h0000);
        rdchk(16'h4300, 16'h0000);
        $display("test reset values done");
    endtask : t_reset

    task automatic t_pulse();
        wr(16'h4318, 16'h00ff);
        wr(16'h4304, 16'h0001);
        ce_i <= 1'b0;
        src_line_i <= 8'h08;
        @(posedge clk_i);
        ce_i <= 1'b1;
        src_line_i <= 8'h00;
        rdchk(16'h4316, 16'h0000);
        src_line_i <= 8'h08;
        @(posedge clk_i);
        src_line_i <= 8'h00;
        rdchk(16'h4316, 16'h0008);
        chkreq(8'h07, 3'h0);
        wr(16'h4316, 16'h0008);
        rdchk(16'h4316, 16'h0000);
        src_line_i <= 8'h08;
        @(posedge clk_i);
        src_line_i <= 8'h00;
        rdchk(16'h4316, 16'h0008);
        wr(16'h4316, 16'h0008);
        $display("test pulse mode done");
    endtask : t_pulse

    task automatic t_level();
        for (int i = 0; i < 4; i++) begin
            wr(16'h4306 + 16'(2 * i), 16'hffff);
            rdchk(16'h4306 + 16'(2 * i), 16'h1717);
        end
        // flag already set when the write lands, read right behind it
        src_line_i <= 8'h01;
        @(posedge clk_i);
        addr_i <= 16'h4316;
        wdata_i <= 16'h0001;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        rdchk(16'h4316, 16'h0001);
        src_line_i <= 8'h00;
        @(posedge clk_i);
        rdchk(16'h4316, 16'h0000);
        $display("test level mode done");
    endtask : t_level

    task automatic t_arb();
        int n;
        mask <= 3'h7;
        slow <= 1'b1;
        wr(16'h4306, 16'h1313);
        wr(16'h430a, 16'h1613);
        src_line_i <= 8'h12;
        repeat (3) @(posedge clk_i);
        chkreq(8'h05, 3'h3);
        src_line_i <= 8'h32;
        repeat (3) @(posedge clk_i);
        chkreq(8'h09, 3'h6);
        check({15'h0000, ack}, 16'h0000);
        mask <= 3'h0;
        for (n = 0; n < 20 && ack !== 1'b1; n++)
            @(posedge clk_i);
        check(16'(n < 20), 16'h0001);
        src_line_i <= 8'h12;
        repeat (3) @(posedge clk_i);
        chkreq(8'h05, 3'h3);
        wr(16'h4318, 16'h00fd);
        chkreq(8'h08, 3'h3);
        src_line_i <= 8'h00;
        repeat (3) @(posedge clk_i);
        $display("test arbitration done");
    endtask : t_arb

    task automatic t_evt();
        rdchk(16'h431a, 16'h0007);
        // output lags the mask by one cycle, settled once wr returns
        wr(16'h431c, 16'h0007);
        #1 check({15'h0000, evt_irq_o}, 16'h0001);
        wr(16'h431c, 16'h0000);
        #1 check({15'h0000, evt_irq_o}, 16'h0000);
        wr(16'h431a, 16'h0007);
        rdchk(16'h431a, 16'h0000);
        check({15'h0000, evt_irq_o}, 16'h0000);
        $display("test event interrupt done");
    endtask : t_evt

    // reset, then the scenarios in order
    initial begin
        repeat (20) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        t_reset();
        t_pulse();
        t_level();
        t_arb();
        t_evt();
        final_report();
    end
endmodule : tb_ext_irq_level_trigger
`default_nettype wire
